// ===== pkg/pscr_pkg.sv
// Package of constants and carriers for the supply enable and buck one control register bank
package pscr_pkg;
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_CONV_EN   = 16'h4050;
    localparam logic [15:0] IDX_REG_EN    = 16'h4051;
    localparam logic [15:0] IDX_CONV_STS  = 16'h4052;
    localparam logic [15:0] IDX_REG_STS   = 16'h4053;
    localparam logic [15:0] IDX_CTL_A     = 16'h4056;
    localparam logic [15:0] IDX_CTL_B     = 16'h4057;
    localparam logic [15:0] IDX_ON_CFG    = 16'h4058;
    localparam logic [15:0] IDX_SLP_CFG   = 16'h405a;
    localparam logic [15:0] IDX_INT_STS   = 16'h4060;
    localparam logic [15:0] IDX_INT_CLR   = 16'h4061;
    localparam logic [15:0] IDX_INT_EN    = 16'h4062;
    // Software write masks and reset values
    localparam logic [15:0] CONV_EN_MASK  = 16'h00cf;
    localparam logic [15:0] REG_EN_MASK   = 16'h07ff;
    localparam logic [15:0] CTL_A_WMASK   = 16'hd0b0;
    localparam logic [15:0] CTL_B_WMASK   = 16'hdc00;
    localparam logic [15:0] ON_CFG_WMASK  = 16'he07f;
    localparam logic [15:0] SLP_CFG_WMASK = 16'h007f;
    localparam logic [15:0] CTL_A_RST     = 16'h8000;
    localparam logic [15:0] ZERO_RST      = 16'h0000;
    // Field positions
    localparam int RATE_LSB = 14;
    localparam int PHASE_BIT = 12;
    localparam int FREQ_LSB = 8;
    localparam int FLOAT_BIT = 7;
    localparam int SS_LSB = 4;
    localparam int CAP_LSB = 0;
    localparam int ACT_LSB = 14;
    localparam int SRC_LSB = 11;
    localparam int VPICK_BIT = 10;
    localparam int SLOT_LSB = 13;
    localparam int EXT1_BIT = 6;
    localparam int EXT2_BIT = 7;
    localparam int INT_UV_BIT = 0;
    localparam int INT_SS_BIT = 1;
    // Timing
    localparam int CLK_MHZ = 10;
    localparam int RAMP_32_US = 32;
    localparam int RAMP_16_US = 16;
    localparam int RAMP_8_US = 8;
    localparam int SS_BASE_US = 32;
    localparam logic [11:0] RAMP_32_CYC = 12'(RAMP_32_US * CLK_MHZ);
    localparam logic [11:0] RAMP_16_CYC = 12'(RAMP_16_US * CLK_MHZ);
    localparam logic [11:0] RAMP_8_CYC  = 12'(RAMP_8_US * CLK_MHZ);
    localparam logic [11:0] SS_BASE_CYC = 12'(SS_BASE_US * CLK_MHZ);
    localparam logic [2:0] SS_LAST_STEP = 3'h7;
    // Field codes
    localparam logic [1:0] RATE_NOW   = 2'b11;
    localparam logic [1:0] ACT_IGNORE = 2'b00;
    localparam logic [1:0] ACT_SHUT   = 2'b01;
    localparam logic [1:0] ACT_RESET  = 2'b10;
    typedef enum logic [1:0] {
        SS_OFF  = 2'b00,
        SS_RAMP = 2'b01,
        SS_ON   = 2'b10
    } pscr_ss_e;
    // Drive towards the first buck converter's power stage
    typedef struct packed {
        logic [6:0] vsel;
        logic       clk_inv;
        logic [1:0] freq;
        logic       discharge;
        logic [2:0] ilim_step;
        logic       run;
    } pscr_buck_drv_s;
endpackage

// ===== hdl/pscr_regs.sv
// Supply enable, status and buck one control register bank on APB
//
// Contract
// - Four buck enable-request bits in bits 3:0, reset to 0.
// - Eleven regulator enable-request bits in bits 10:0, reset to 0.
// - Actual buck and regulator states in separate status registers, reset 0.
// - External power output requests in bits 6 and 7, reset 0.
// - External power output actual states in status bits 6 and 7.
// - Buck one voltage steps every 32, 16, 8us or immediately; reset 10.
// - Bit 12 inverts buck one switching clock phase; reset 0.
// - Bits 9:8 select 2 or 4 MHz switching; reset 00.
// - Frequency and capacitor fields change only during configuration load.
// - Disabled buck one output discharged unless float bit set.
// - Buck one starts in 8 current-limit steps of 32 to 256us.
// - Undervoltage action: ignore, shut down converter, or device reset.
// - Every buck one undervoltage fault raises an interrupt.
// - Bits 12:11 choose which hardware control input governs buck one.
// - Under hardware control bit 10 picks normal or sleep voltage.
// - Slot fields and upper five voltage bits load from configuration.
// - Fault shutdown clears that supply's request and status bits.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module pscr_regs
    import pscr_pkg::*;
#(
    parameter int NUM_BUCK = 4,
    parameter int NUM_LDO  = 11
) (
    // Clock and reset
    input  wire logic                    MCLK,
    input  wire logic                    RST,
    // APB slave
    input  wire logic                    PSEL,
    input  wire logic                    PENABLE,
    input  wire logic                    PWRITE,
    input  wire logic [17:0]             PADDR,
    input  wire logic [31:0]             PWDATA,
    output logic      [31:0]             PRDATA,
    output logic                         PREADY,
    output logic                         PSLVERR,
    // Configuration load from nonvolatile or external memory
    input  wire logic                    CFG_LOAD,
    input  wire logic [1:0]              CFG_FREQ,
    input  wire logic [1:0]              CFG_CAP,
    input  wire logic [2:0]              CFG_SLOT,
    input  wire logic [4:0]              CFG_VSEL_HI,
    // Pins from outside the clock domain
    input  wire logic                    BUCK1_UV,
    input  wire logic [1:0]              HW_CTRL,
    // Supply controls
    output logic      [NUM_BUCK-1:0]     BUCK_RUN,
    output logic      [NUM_LDO-1:0]      LDO_RUN,
    output logic      [1:0]              EXT_PWR,
    output pscr_pkg::pscr_buck_drv_s     BUCK1_DRV,
    output logic                         DEV_RESET_REQ,
    output logic                         IRQ
);
    import pscr_pkg::*;

    typedef struct packed {
        logic [15:0] conv_en;
        logic [15:0] reg_en;
        logic [15:0] conv_sts;
        logic [15:0] reg_sts;
        logic [15:0] ctl_a;
        logic [15:0] ctl_b;
        logic [15:0] on_cfg;
        logic [15:0] slp_cfg;
        logic [1:0]  int_sts;
        logic [1:0]  int_en;
        logic [1:0]  uv_sync;
        logic        uv_last;
        logic [1:0]  hw0_sync;
        logic [1:0]  hw1_sync;
        pscr_ss_e    ss;
        logic [2:0]  ss_step;
        logic [11:0] ss_cnt;
        logic [6:0]  vcur;
        logic [11:0] ramp_cnt;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        rst_req;
        logic        irq;
        pscr_buck_drv_s drv;
    } pscr_state_s;

    pscr_state_s st_r;
    pscr_state_s st_nxt;

    logic        setup;
    logic        wr_acc;
    logic [15:0] idx;
    logic        mapped;
    logic [15:0] wd;
    logic        uv_evt;
    logic        hw_active;
    logic [6:0]  vtgt;
    logic [11:0] ramp_per;
    logic [11:0] ss_len;
    logic        shut;

    assign setup  = PSEL && !PENABLE;
    assign wr_acc = PSEL && PENABLE && PWRITE && st_r.ready;
    assign idx    = PADDR[17:2];
    assign wd     = PWDATA[15:0];
    assign mapped = (PADDR[1:0] == 2'b00) &&
                    (idx inside {IDX_CONV_EN, IDX_REG_EN, IDX_CONV_STS, IDX_REG_STS,
                                 IDX_CTL_A, IDX_CTL_B, IDX_ON_CFG, IDX_SLP_CFG,
                                 IDX_INT_STS, IDX_INT_CLR, IDX_INT_EN});
    // Only the second stage of each synchroniser is looked at
    assign uv_evt = st_r.uv_sync[1] && !st_r.uv_last;
    assign shut   = uv_evt && (st_r.ctl_b[ACT_LSB +: 2] == ACT_SHUT);

    always_comb begin
        case (st_r.ctl_b[SRC_LSB +: 2])
            2'b01:   hw_active = st_r.hw0_sync[1];
            2'b10:   hw_active = st_r.hw1_sync[1];
            2'b11:   hw_active = st_r.hw0_sync[1] || st_r.hw1_sync[1];
            default: hw_active = 1'b0;
        endcase
    end

    assign vtgt = (hw_active && st_r.ctl_b[VPICK_BIT]) ? st_r.slp_cfg[6:0] : st_r.on_cfg[6:0];

    always_comb begin
        case (st_r.ctl_a[RATE_LSB +: 2])
            2'b00:   ramp_per = RAMP_32_CYC;
            2'b01:   ramp_per = RAMP_16_CYC;
            default: ramp_per = RAMP_8_CYC;
        endcase
    end

    assign ss_len = SS_BASE_CYC << st_r.ctl_a[SS_LSB +: 2];

    always_comb begin
        st_nxt = st_r;
        st_nxt.uv_sync  = {st_r.uv_sync[0], BUCK1_UV};
        st_nxt.uv_last  = st_r.uv_sync[1];
        st_nxt.hw0_sync = {st_r.hw0_sync[0], HW_CTRL[0]};
        st_nxt.hw1_sync = {st_r.hw1_sync[0], HW_CTRL[1]};
        st_nxt.rst_req  = 1'b0;

        // APB: read data and ready prepared in setup, shown in the single access cycle
        st_nxt.ready  = setup;
        st_nxt.slverr = setup && !mapped;
        st_nxt.rdata  = 32'h0;
        if (setup && !PWRITE) begin
            case (idx)
                IDX_CONV_EN:  st_nxt.rdata = {16'h0, st_r.conv_en};
                IDX_REG_EN:   st_nxt.rdata = {16'h0, st_r.reg_en};
                IDX_CONV_STS: st_nxt.rdata = {16'h0, st_r.conv_sts};
                IDX_REG_STS:  st_nxt.rdata = {16'h0, st_r.reg_sts};
                IDX_CTL_A:    st_nxt.rdata = {16'h0, st_r.ctl_a};
                IDX_CTL_B:    st_nxt.rdata = {16'h0, st_r.ctl_b};
                IDX_ON_CFG:   st_nxt.rdata = {16'h0, st_r.on_cfg};
                IDX_SLP_CFG:  st_nxt.rdata = {16'h0, st_r.slp_cfg};
                IDX_INT_STS:  st_nxt.rdata = {30'h0, st_r.int_sts};
                IDX_INT_EN:   st_nxt.rdata = {30'h0, st_r.int_en};
                default:      st_nxt.rdata = 32'h0;
            endcase
        end

        // Software writes; status registers have no write path
        if (wr_acc && mapped) begin
            case (idx)
                IDX_CONV_EN: st_nxt.conv_en = wd & CONV_EN_MASK;
                IDX_REG_EN:  st_nxt.reg_en = wd & REG_EN_MASK;
                IDX_CTL_A: begin
                    st_nxt.ctl_a = (wd & CTL_A_WMASK) | (st_r.ctl_a & ~CTL_A_WMASK);
                end
                IDX_CTL_B: begin
                    st_nxt.ctl_b = (wd & CTL_B_WMASK) | (st_r.ctl_b & ~CTL_B_WMASK);
                end
                IDX_ON_CFG: begin
                    st_nxt.on_cfg = (wd & ON_CFG_WMASK) | (st_r.on_cfg & ~ON_CFG_WMASK);
                end
                IDX_SLP_CFG: st_nxt.slp_cfg = wd & SLP_CFG_WMASK;
                IDX_INT_EN:  st_nxt.int_en = wd[1:0];
                IDX_INT_CLR: st_nxt.int_sts = st_r.int_sts & ~wd[1:0];
                default: ;
            endcase
        end

        // Configuration load is the only path into frequency and capacitor fields
        if (CFG_LOAD) begin
            st_nxt.ctl_a[FREQ_LSB +: 2] = CFG_FREQ;
            st_nxt.ctl_a[CAP_LSB +: 2]  = CFG_CAP;
            st_nxt.on_cfg[SLOT_LSB +: 3] = CFG_SLOT;
            st_nxt.on_cfg[6:2]           = CFG_VSEL_HI;
        end

        // Actual states follow requests; buck one waits for soft start
        st_nxt.conv_sts = {8'h0, st_r.conv_en[EXT2_BIT], st_r.conv_en[EXT1_BIT], 2'b00,
                           st_r.conv_en[3:1], st_r.ss == SS_ON};
        st_nxt.reg_sts  = st_r.reg_en & REG_EN_MASK;

        // Soft start of buck one
        case (st_r.ss)
            SS_OFF: begin
                if (st_r.conv_en[0]) begin
                    st_nxt.ss      = SS_RAMP;
                    st_nxt.ss_step = 3'h0;
                    st_nxt.ss_cnt  = 12'h0;
                end
            end
            SS_RAMP: begin
                if (!st_r.conv_en[0]) begin
                    st_nxt.ss = SS_OFF;
                end else if (st_r.ss_cnt == ss_len - 12'h1) begin
                    st_nxt.ss_cnt = 12'h0;
                    if (st_r.ss_step == SS_LAST_STEP) begin
                        st_nxt.ss = SS_ON;
                    end else begin
                        st_nxt.ss_step = st_r.ss_step + 3'h1;
                    end
                end else begin
                    st_nxt.ss_cnt = st_r.ss_cnt + 12'h1;
                end
            end
            SS_ON: begin
                if (!st_r.conv_en[0]) begin
                    st_nxt.ss = SS_OFF;
                end
            end
            default: st_nxt.ss = SS_OFF;
        endcase

        // Output voltage ramp, one code step per period, or straight to target at RATE_NOW
        if (st_r.vcur == vtgt) begin
            st_nxt.ramp_cnt = 12'h0;
        end else if (st_r.ctl_a[RATE_LSB +: 2] == RATE_NOW) begin
            st_nxt.vcur = vtgt;
        end else if (st_r.ramp_cnt == ramp_per - 12'h1) begin
            st_nxt.ramp_cnt = 12'h0;
            st_nxt.vcur = (st_r.vcur < vtgt) ? st_r.vcur + 7'h1 : st_r.vcur - 7'h1;
        end else begin
            st_nxt.ramp_cnt = st_r.ramp_cnt + 12'h1;
        end

        // Undervoltage fault; fault shutdown beats a same-cycle software write
        if (shut) begin
            st_nxt.conv_en[0]  = 1'b0;
            st_nxt.conv_sts[0] = 1'b0;
            st_nxt.ss          = SS_OFF;
        end
        if (uv_evt && st_r.ctl_b[ACT_LSB +: 2] == ACT_RESET) begin
            st_nxt.rst_req = 1'b1;
        end

        // Interrupt events win over a same-cycle clear
        if (uv_evt) begin
            st_nxt.int_sts[INT_UV_BIT] = 1'b1;
        end
        if (st_r.ss == SS_RAMP && st_nxt.ss == SS_ON) begin
            st_nxt.int_sts[INT_SS_BIT] = 1'b1;
        end
        st_nxt.irq = |(st_nxt.int_sts & st_nxt.int_en);

        // Power stage drive taken from next state, so it leaves a flop without extra lag
        st_nxt.drv.vsel      = st_nxt.vcur;
        st_nxt.drv.clk_inv   = st_nxt.ctl_a[PHASE_BIT];
        st_nxt.drv.freq      = st_nxt.ctl_a[FREQ_LSB +: 2];
        st_nxt.drv.discharge = !st_nxt.conv_sts[0] && !st_nxt.ctl_a[FLOAT_BIT];
        st_nxt.drv.ilim_step = st_nxt.ss_step;
        st_nxt.drv.run       = st_nxt.ss != SS_OFF;
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            st_r         <= '0;
            st_r.ctl_a   <= CTL_A_RST;
            st_r.ctl_b   <= ZERO_RST;
            st_r.ss      <= SS_OFF;
            st_r.drv.discharge <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Output drive from state flops
    assign PRDATA        = st_r.rdata;
    assign PREADY        = st_r.ready;
    assign PSLVERR       = st_r.slverr;
    assign BUCK_RUN      = st_r.conv_sts[NUM_BUCK-1:0];
    assign LDO_RUN       = st_r.reg_sts[NUM_LDO-1:0];
    assign EXT_PWR       = {st_r.conv_sts[EXT2_BIT], st_r.conv_sts[EXT1_BIT]};
    assign DEV_RESET_REQ = st_r.rst_req;
    assign IRQ           = st_r.irq;
    assign BUCK1_DRV     = st_r.drv;

    // Checks
    sequence s_uv_shut;
        uv_evt && st_r.ctl_b[ACT_LSB +: 2] == ACT_SHUT;
    endsequence
    property p_req_reset;
        @(posedge MCLK) $fell(RST) |-> (st_r.conv_en == 16'h0 && st_r.ctl_a == CTL_A_RST);
    endproperty
    a_req_reset: assert property (p_req_reset) else $error("defaults lost");
    property p_buck_sts;
        @(posedge MCLK) disable iff (RST)
        ##1 st_r.conv_sts[3:1] == $past(st_r.conv_en[3:1]) &&
            st_r.conv_sts[7:6] == $past(st_r.conv_en[7:6]);
    endproperty
    a_buck_sts: assert property (p_buck_sts) else $error("buck status stale");
    property p_ldo_sts;
        @(posedge MCLK) disable iff (RST) ##1 st_r.reg_sts == $past(st_r.reg_en);
    endproperty
    a_ldo_sts: assert property (p_ldo_sts) else $error("regulator_actual_status stale");
    property p_ext;
        @(posedge MCLK) disable iff (RST)
        $rose(st_r.conv_en[EXT2_BIT]) |=> EXT_PWR[1] && st_r.conv_sts[EXT2_BIT];
    endproperty
    a_ext: assert property (p_ext) else $error("ext output late");
    property p_ramp_now;
        @(posedge MCLK) disable iff (RST)
        (st_r.ctl_a[RATE_LSB +: 2] == RATE_NOW && st_r.vcur != vtgt) |=> st_r.vcur == $past(vtgt);
    endproperty
    a_ramp_now: assert property (p_ramp_now) else $error("immediate ramp slow");
    property p_ro_fields;
        @(posedge MCLK) disable iff (RST)
        !CFG_LOAD |=> $stable(st_r.ctl_a[1:0]) && $stable(st_r.ctl_a[9:8]);
    endproperty
    a_ro_fields: assert property (p_ro_fields) else $error("read-only field moved");
    property p_uv_shut;
        @(posedge MCLK) disable iff (RST)
        s_uv_shut |=> !st_r.conv_en[0] ##1 !st_r.conv_sts[0];
    endproperty
    a_uv_shut: assert property (p_uv_shut) else $error("fault shutdown missed");
    property p_uv_irq;
        @(posedge MCLK) disable iff (RST) uv_evt |=> st_r.int_sts[INT_UV_BIT];
    endproperty
    a_uv_irq: assert property (p_uv_irq) else $error("fault not flagged");
    property p_ss_min;
        @(posedge MCLK) disable iff (RST)
        $rose(st_r.ss == SS_RAMP) |-> !(st_r.ss == SS_ON)[*8];
    endproperty
    a_ss_min: assert property (p_ss_min) else $error("soft start too short");
    property p_discharge;
        @(posedge MCLK) disable iff (RST)
        BUCK1_DRV.discharge |-> !st_r.ctl_a[FLOAT_BIT] && !BUCK_RUN[0];
    endproperty
    a_discharge: assert property (p_discharge) else $error("discharge wrong");
    sequence s_ss_done;
        st_r.ss == SS_RAMP && st_nxt.ss == SS_ON;
    endsequence
    property p_ss_done;
        @(posedge MCLK) disable iff (RST)
        s_ss_done |-> (st_r.ss_step == SS_LAST_STEP && st_r.ss_cnt == ss_len - 12'h1) ##1
            st_r.int_sts[INT_SS_BIT];
    endproperty
    a_ss_done: assert property (p_ss_done) else $error("soft start step count wrong");
    property p_uv_reset;
        @(posedge MCLK) disable iff (RST)
        (uv_evt && st_r.ctl_b[ACT_LSB +: 2] == ACT_RESET) |=> DEV_RESET_REQ ##1 !DEV_RESET_REQ;
    endproperty
    a_uv_reset: assert property (p_uv_reset) else $error("reset request wrong");
    property p_uv_ignore;
        @(posedge MCLK) disable iff (RST)
        (uv_evt && st_r.ctl_b[ACT_LSB +: 2] == ACT_IGNORE && !wr_acc) |=>
            st_r.conv_en[0] == $past(st_r.conv_en[0]) && !DEV_RESET_REQ;
    endproperty
    a_uv_ignore: assert property (p_uv_ignore) else $error("ignored fault acted on");
    property p_ramp_hold;
        @(posedge MCLK) disable iff (RST)
        (st_r.vcur != vtgt && st_r.ctl_a[RATE_LSB +: 2] != RATE_NOW &&
         st_r.ramp_cnt != ramp_per - 12'h1) |=> $stable(st_r.vcur);
    endproperty
    a_ramp_hold: assert property (p_ramp_hold) else $error("voltage stepped early");
    property p_sts_ro;
        @(posedge MCLK) disable iff (RST)
        (wr_acc && !uv_evt && (idx == IDX_CONV_STS || idx == IDX_REG_STS)) |=>
            st_r.conv_en == $past(st_r.conv_en) && st_r.reg_sts == $past(st_r.reg_en);
    endproperty
    a_sts_ro: assert property (p_sts_ro) else $error("status took a write");
    property p_irq;
        @(posedge MCLK) disable iff (RST) IRQ == |(st_r.int_sts & st_r.int_en);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt line wrong");
endmodule // pscr_regs
`default_nettype wire

// ===== testbench/pscr_regs_bench.sv
// Self-checking bench for the supply enable and buck one control register bank
`timescale 1ns/1ps
`default_nettype none
module pscr_regs_bench;
    import pscr_pkg::*;

    logic           mclk = 1'b0;
    logic           rst = 1'b1;
    logic           psel = 1'b0;
    logic           penable = 1'b0;
    logic           pwrite = 1'b0;
    logic [17:0]    paddr = '0;
    logic [31:0]    pwdata = '0;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    logic           cfg_load = 1'b0;
    logic [1:0]     cfg_freq = '0;
    logic [1:0]     cfg_cap = '0;
    logic [2:0]     cfg_slot = '0;
    logic [4:0]     cfg_vsel_hi = '0;
    logic           uv = 1'b0;
    logic [1:0]     hw = '0;
    logic [3:0]     buck_run;
    logic [10:0]    ldo_run;
    logic [1:0]     ext_pwr;
    pscr_buck_drv_s drv;
    logic           dev_rst;
    logic           irq;
    int             err_count = 0;
    int             check_count = 0;
    int             rst_pulses = 0;
    logic [31:0]    rv;
    logic           re;

    pscr_regs i_dut (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CFG_LOAD(cfg_load), .CFG_FREQ(cfg_freq), .CFG_CAP(cfg_cap), .CFG_SLOT(cfg_slot),
        .CFG_VSEL_HI(cfg_vsel_hi), .BUCK1_UV(uv), .HW_CTRL(hw), .BUCK_RUN(buck_run),
        .LDO_RUN(ldo_run), .EXT_PWR(ext_pwr), .BUCK1_DRV(drv), .DEV_RESET_REQ(dev_rst),
        .IRQ(irq));

    always #50 mclk = ~mclk;

    always @(posedge mclk) begin
        if (dev_rst === 1'b1) rst_pulses++;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Access phase lasts until PREADY is sampled high; only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1);
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("apb_wait", 1, n);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        apb(1'b1, idx, {16'h0000, d});
    endtask

    task automatic rdc(input string name, input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        chk(name, exp, rv);
    endtask

    task automatic t_reset_values;
        rdc("conv_en", IDX_CONV_EN, 32'h0000_0000);
        rdc("reg_en", IDX_REG_EN, 32'h0000_0000);
        rdc("conv_sts", IDX_CONV_STS, 32'h0000_0000);
        rdc("reg_sts", IDX_REG_STS, 32'h0000_0000);
        rdc("ctl_a", IDX_CTL_A, 32'h0000_8000);
        rdc("ctl_b", IDX_CTL_B, 32'h0000_0000);
        chk("discharge", 1, drv.discharge);
        chk("irq", 0, irq);
        chk("run_off", 0, drv.run);
    endtask

    task automatic t_enables;
        wr(IDX_CONV_EN, 16'hfffe);
        rdc("conv_en_mask", IDX_CONV_EN, 32'h0000_00ce);
        wr(IDX_REG_EN, 16'hffff);
        rdc("reg_en_mask", IDX_REG_EN, 32'h0000_07ff);
        wr(IDX_CONV_STS, 16'h0000);
        rdc("conv_sts_on", IDX_CONV_STS, 32'h0000_00ce);
        rdc("reg_sts_on", IDX_REG_STS, 32'h0000_07ff);
        chk("ext_pwr", 2'b11, ext_pwr);
        chk("ldo_run", 11'h7ff, ldo_run);
        chk("buck_run", 4'he, buck_run);
        apb(1'b0, 16'h4059, 32'h0000_0000);
        chk("unmapped_err", 1, re);
        chk("unmapped_data", 0, rv);
        rdc("int_clr_reads0", IDX_INT_CLR, 32'h0000_0000);
        wr(IDX_CONV_EN, 16'h0000);
        wr(IDX_REG_EN, 16'h0000);
        rdc("conv_sts_off", IDX_CONV_STS, 32'h0000_0000);
    endtask

    task automatic t_soft_start;
        int n;
        n = 0;
        wr(IDX_CONV_EN, 16'h0001);
        while (buck_run[0] !== 1'b1 && n < 3000) begin
            @(posedge mclk);
            n++;
        end
        // Eight steps of the shortest length, plus a few cycles of pipeline
        chk("ss_cycles", 1, n >= 8 * 320 && n <= 2570);
        chk("ilim_last", 3'h7, drv.ilim_step);
        chk("run_on", 1, drv.run);
        rdc("int_sts_ss", IDX_INT_STS, 32'h0000_0002);
        wr(IDX_INT_EN, 16'h0002);
        cyc(2);
        chk("irq_set", 1, irq);
        wr(IDX_INT_EN, 16'h0000);
        cyc(2);
        chk("irq_masked", 0, irq);
        wr(IDX_INT_EN, 16'h0002);
        wr(IDX_INT_CLR, 16'h0002);
        cyc(2);
        chk("irq_cleared", 0, irq);
        rdc("int_sts_clr", IDX_INT_STS, 32'h0000_0000);
    endtask

    task automatic t_ramp_hw;
        wr(IDX_ON_CFG, 16'h0003);
        cyc(100);
        chk("ramp_slow", 1, drv.vsel !== 7'h03);
        cyc(200);
        chk("ramp_done", 7'h03, drv.vsel);
        wr(IDX_CTL_A, 16'h4000);
        wr(IDX_ON_CFG, 16'h0004);
        cyc(100);
        chk("ramp_16_wait", 7'h03, drv.vsel);
        cyc(100);
        chk("ramp_16_step", 7'h04, drv.vsel);
        wr(IDX_CTL_A, 16'h0000);
        wr(IDX_ON_CFG, 16'h0005);
        cyc(250);
        chk("ramp_32_wait", 7'h04, drv.vsel);
        cyc(100);
        chk("ramp_32_step", 7'h05, drv.vsel);
        wr(IDX_CTL_A, 16'hc000);
        wr(IDX_ON_CFG, 16'h0040);
        cyc(4);
        chk("ramp_now", 7'h40, drv.vsel);
        wr(IDX_SLP_CFG, 16'h0011);
        wr(IDX_CTL_B, 16'h0c00);
        hw <= 2'b10;
        cyc(8);
        chk("hw_src_other", 7'h40, drv.vsel);
        hw <= 2'b01;
        cyc(8);
        chk("hw_sleep_v", 7'h11, drv.vsel);
        wr(IDX_CTL_B, 16'h1c00);
        hw <= 2'b10;
        cyc(8);
        chk("hw_either", 7'h11, drv.vsel);
        hw <= 2'b00;
        cyc(8);
        chk("hw_release", 7'h40, drv.vsel);
        wr(IDX_CTL_B, 16'h1400);
        hw <= 2'b10;
        cyc(8);
        chk("hw_src_two", 7'h11, drv.vsel);
        hw <= 2'b00;
        wr(IDX_CTL_B, 16'h0000);
    endtask

    task automatic t_config_load;
        wr(IDX_CTL_A, 16'hffff);
        rdc("ctl_a_ro", IDX_CTL_A, 32'h0000_d0b0);
        chk("clk_inv", 1, drv.clk_inv);
        @(posedge mclk);
        cfg_load <= 1'b1;
        cfg_freq <= 2'b01;
        cfg_cap <= 2'b10;
        cfg_slot <= 3'h5;
        cfg_vsel_hi <= 5'h13;
        @(posedge mclk);
        cfg_load <= 1'b0;
        rdc("ctl_a_load", IDX_CTL_A, 32'h0000_d1b2);
        chk("freq_drv", 2'b01, drv.freq);
        rdc("on_cfg_load", IDX_ON_CFG, 32'h0000_a04c);
        wr(IDX_CTL_A, 16'h0000);
        rdc("ctl_a_keep", IDX_CTL_A, 32'h0000_0102);
        chk("clk_norm", 0, drv.clk_inv);
    endtask

    task automatic t_undervoltage;
        logic [1:0] acts [3];
        acts = '{ACT_IGNORE, ACT_RESET, ACT_SHUT};
        wr(IDX_INT_EN, 16'h0001);
        foreach (acts[i]) begin
            wr(IDX_CTL_B, {acts[i], 14'h0000});
            wr(IDX_INT_CLR, 16'h0003);
            rst_pulses = 0;
            uv <= 1'b1;
            cyc(6);
            uv <= 1'b0;
            cyc(4);
            rdc("uv_int", IDX_INT_STS, 32'h0000_0001);
            chk("uv_irq", 1, irq);
            chk("uv_reset_req", acts[i] == ACT_RESET, rst_pulses == 1);
            rdc("uv_conv_en", IDX_CONV_EN, {31'h0, acts[i] != ACT_SHUT});
            rdc("uv_conv_sts", IDX_CONV_STS, {31'h0, acts[i] != ACT_SHUT});
        end
        wr(IDX_CTL_A, 16'h0080);
        cyc(2);
        chk("float", 0, drv.discharge);
        wr(IDX_CTL_A, 16'h0000);
        cyc(2);
        chk("discharge", 1, drv.discharge);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Longest scenario is one soft start of about 2600 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        summarize();
    end

    initial begin
        cyc(2);
        rst <= 1'b0;
        t_reset_values();
        t_enables();
        t_soft_start();
        t_ramp_hw();
        t_config_load();
        t_undervoltage();
        summarize();
    end
endmodule // pscr_regs_bench
`default_nettype wire
